// ---- erps_cfg.svh ----
`ifndef ERPS_CFG_SVH
`define ERPS_CFG_SVH
// Clock rate in kHz.
`define ERPS_CLK_KHZ 25000
// Program pulse nominal width and tolerance window, in microseconds.
`define ERPS_PW_US 100
`define ERPS_PW_MIN_US 95
`define ERPS_PW_MAX_US 105
// Setup and hold times, in microseconds.
`define ERPS_SETUP_US 2
// Data valid from output enable, in nanoseconds.
`define ERPS_TOE_NS 150
// Additional program pulses allowed per byte.
`define ERPS_MAX_RETRY 10
// Cycle counts derived from the times above.
`define ERPS_PW_CYC ((`ERPS_PW_US * `ERPS_CLK_KHZ) / 1000)
`define ERPS_SETUP_CYC ((`ERPS_SETUP_US * `ERPS_CLK_KHZ + 999) / 1000)
`define ERPS_TOE_CYC ((`ERPS_TOE_NS * `ERPS_CLK_KHZ + 999999) / 1000000)
`endif

// ---- erps_pkg.sv ----
package erps_pkg;
  typedef enum {
    ERPS_IDLE, ERPS_PWR_VCC, ERPS_PWR_VPP, ERPS_SETUP, ERPS_PULSE, ERPS_HOLD,
    ERPS_VREAD, ERPS_VCMP, ERPS_NEXT, ERPS_PWR_DOWN, ERPS_PWR_OFF, ERPS_FREAD,
    ERPS_FCMP, ERPS_ID, ERPS_DONE
  } erps_state_t;
  typedef enum {ERPS_PH_FIRST, ERPS_PH_VERIFY} erps_phase_t;
endpackage

// ---- erps_sequencer.sv ----
// Function
// - Program strobe pulse 100 us, within 95-105.
// - First pass: one pulse per address, no verify.
// - Verify loop; up to 10 extra pulses, verify each.
// - Still mismatching after 10 extra pulses: part failed.
// - Verified byte advances address until all checked.
// - Raise main to 6.5V, program supply 13V.
// - Main supply on first, off last.
// - Drop supplies to 5V, reread and compare all; a part already failed is not reread.
// - Id select line held at elevated voltage.
`timescale 1ns/10ps
`include "erps_cfg.svh"
module erps_sequencer
  import erps_pkg::*;
#(
  parameter int ADDR_W = 17,
  parameter int PW_CYC = `ERPS_PW_CYC
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic start_prog,
  input wire logic start_id,
  input wire logic [ADDR_W-1:0] last_addr,
  output logic [ADDR_W-1:0] data_addr,
  input wire logic [7:0] data_in,
  output logic [ADDR_W-1:0] mem_addr,
  output logic chip_en_n,
  output logic out_en_n,
  output logic program_strobe_n,
  output logic id_select_hv,
  output logic [7:0] mem_data_out,
  output logic mem_data_oe_n,
  input wire logic [7:0] mem_data_in,
  output logic vcc_prog,
  output logic vcc_on,
  output logic vpp_prog,
  output logic vpp_on,
  output logic busy,
  output logic done,
  output logic fail,
  output logic [7:0] id_maker,
  output logic [7:0] id_type
);
  localparam int SETUP_CYC = `ERPS_SETUP_CYC;
  localparam int TOE_CYC = `ERPS_TOE_CYC;

  typedef struct packed {
    erps_state_t st;
    erps_phase_t ph;
    logic [ADDR_W-1:0] addr;
    logic [15:0] cnt;
    logic [3:0] retry;
    logic [7:0] q1;
    logic [7:0] q2;
    logic ce_n, oe_n, pgm_n, id_hv, d_oe_n;
    logic vcc_p, vcc_o, vpp_p, vpp_o;
    logic done, fail;
    logic [7:0] idm, idt;
    logic [7:0] dout;
  } erps_s_t;

  erps_s_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.q1 = mem_data_in;
    s_next.q2 = s_reg.q1;
    s_next.dout = data_in;
    if (s_reg.cnt != 16'h0000) begin
      s_next.cnt = s_reg.cnt - 16'h0001;
    end
    case (s_reg.st)
      ERPS_IDLE: begin
        if (start_prog) begin
          s_next.done = 1'b0;
          s_next.fail = 1'b0;
          s_next.vcc_o = 1'b1;
          s_next.vcc_p = 1'b1;
          s_next.cnt = 16'(SETUP_CYC);
          s_next.st = ERPS_PWR_VCC;
        end else if (start_id) begin
          s_next.done = 1'b0;
          s_next.vcc_o = 1'b1;
          s_next.id_hv = 1'b1;
          s_next.ce_n = 1'b0;
          s_next.oe_n = 1'b0;
          s_next.addr = '0;
          s_next.retry = 4'h0;
          s_next.cnt = 16'(SETUP_CYC);
          s_next.st = ERPS_ID;
        end
      end
      ERPS_PWR_VCC: begin
        if (s_reg.cnt == 16'h0000) begin
          s_next.vpp_o = 1'b1;
          s_next.vpp_p = 1'b1;
          s_next.addr = '0;
          s_next.ph = ERPS_PH_FIRST;
          s_next.retry = 4'h0;
          s_next.cnt = 16'(SETUP_CYC);
          s_next.st = ERPS_PWR_VPP;
        end
      end
      ERPS_PWR_VPP, ERPS_HOLD: begin
        if (s_reg.cnt == 16'h0000) begin
          s_next.d_oe_n = 1'b0;
          s_next.ce_n = 1'b0;
          s_next.oe_n = 1'b1;
          s_next.cnt = 16'(SETUP_CYC);
          s_next.st = (s_reg.st == ERPS_HOLD) ? ERPS_VREAD : ERPS_SETUP;
          if (s_reg.st == ERPS_HOLD) begin
            s_next.d_oe_n = 1'b1;
            s_next.oe_n = 1'b0;
          end
          if (s_reg.st == ERPS_HOLD && s_reg.ph == ERPS_PH_FIRST) begin
            s_next.oe_n = 1'b1;
            s_next.st = ERPS_NEXT;
          end
        end
      end
      ERPS_SETUP: begin
        if (s_reg.cnt == 16'h0000) begin
          s_next.pgm_n = 1'b0;
          s_next.cnt = 16'(PW_CYC);
          s_next.st = ERPS_PULSE;
        end
      end
      ERPS_PULSE: begin
        if (s_reg.cnt == 16'h0001) begin
          s_next.pgm_n = 1'b1;
          s_next.cnt = 16'(SETUP_CYC);
          s_next.st = ERPS_HOLD;
        end
      end
      ERPS_VREAD: begin
        if (s_reg.cnt == 16'h0000) begin
          s_next.st = ERPS_VCMP;
        end
      end
      ERPS_VCMP: begin
        s_next.oe_n = 1'b1;
        s_next.cnt = 16'(SETUP_CYC);
        if (s_reg.q2 == data_in) begin
          s_next.st = ERPS_NEXT;
        end else if (s_reg.retry == 4'(`ERPS_MAX_RETRY)) begin
          s_next.fail = 1'b1;
          s_next.st = ERPS_PWR_DOWN;
        end else begin
          s_next.retry = s_reg.retry + 4'h1;
          s_next.st = ERPS_PWR_VPP;
        end
      end
      ERPS_NEXT: begin
        if (s_reg.cnt == 16'h0000) begin
          s_next.retry = 4'h0;
          s_next.cnt = 16'(SETUP_CYC);
          if (s_reg.addr == last_addr) begin
            s_next.addr = '0;
            if (s_reg.ph == ERPS_PH_FIRST) begin
              s_next.ph = ERPS_PH_VERIFY;
              s_next.oe_n = 1'b0;
              s_next.st = ERPS_VREAD;
            end else begin
              s_next.st = ERPS_PWR_DOWN;
            end
          end else begin
            s_next.addr = s_reg.addr + 1'b1;
            s_next.oe_n = s_reg.ph == ERPS_PH_FIRST;
            s_next.st = (s_reg.ph == ERPS_PH_FIRST) ? ERPS_SETUP : ERPS_VREAD;
            s_next.d_oe_n = s_reg.ph != ERPS_PH_FIRST;
          end
        end
      end
      ERPS_PWR_DOWN: begin
        s_next.ce_n = 1'b1;
        s_next.oe_n = 1'b1;
        s_next.d_oe_n = 1'b1;
        s_next.vpp_p = 1'b0;
        if (s_reg.cnt == 16'h0000) begin
          s_next.vcc_p = 1'b0;
          s_next.cnt = 16'(SETUP_CYC);
          s_next.st = s_reg.fail ? ERPS_PWR_OFF : ERPS_FREAD;
          s_next.addr = '0;
          s_next.ce_n = s_reg.fail;
          s_next.oe_n = s_reg.fail;
        end
      end
      ERPS_FREAD: begin
        if (s_reg.cnt == 16'h0000) begin
          s_next.st = ERPS_FCMP;
        end
      end
      ERPS_FCMP: begin
        s_next.cnt = 16'(TOE_CYC);
        if (s_reg.q2 != data_in) begin
          s_next.fail = 1'b1;
        end
        if (s_reg.addr == last_addr) begin
          s_next.ce_n = 1'b1;
          s_next.oe_n = 1'b1;
          s_next.cnt = 16'(SETUP_CYC);
          s_next.st = ERPS_PWR_OFF;
        end else begin
          s_next.addr = s_reg.addr + 1'b1;
          s_next.st = ERPS_FREAD;
        end
      end
      ERPS_PWR_OFF: begin
        s_next.vpp_o = 1'b0;
        if (s_reg.cnt == 16'h0000) begin
          s_next.vcc_o = 1'b0;
          s_next.done = 1'b1;
          s_next.st = ERPS_IDLE;
        end
      end
      ERPS_ID: begin
        if (s_reg.cnt == 16'h0000) begin
          if (s_reg.retry == 4'h0) begin
            s_next.idm = s_reg.q2;
            s_next.addr[0] = 1'b1;
            s_next.retry = 4'h1;
            s_next.cnt = 16'(SETUP_CYC);
          end else begin
            s_next.idt = s_reg.q2;
            s_next.retry = 4'h0;
            s_next.addr = '0;
            s_next.ce_n = 1'b1;
            s_next.oe_n = 1'b1;
            s_next.id_hv = 1'b0;
            s_next.vcc_o = 1'b0;
            s_next.done = 1'b1;
            s_next.st = ERPS_IDLE;
          end
        end
      end
      default: begin
        s_next.st = ERPS_IDLE;
      end
    endcase
    if (srst) begin
      s_next = '0;
      s_next.st = ERPS_IDLE;
      s_next.ph = ERPS_PH_FIRST;
      s_next.ce_n = 1'b1;
      s_next.oe_n = 1'b1;
      s_next.pgm_n = 1'b1;
      s_next.d_oe_n = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    s_reg <= s_next;
  end

  assign data_addr = s_reg.addr;
  assign mem_addr = s_reg.addr;
  assign chip_en_n = s_reg.ce_n;
  assign out_en_n = s_reg.oe_n;
  assign program_strobe_n = s_reg.pgm_n;
  assign id_select_hv = s_reg.id_hv;
  assign mem_data_out = s_reg.dout;
  assign mem_data_oe_n = s_reg.d_oe_n;
  assign vcc_prog = s_reg.vcc_p;
  assign vcc_on = s_reg.vcc_o;
  assign vpp_prog = s_reg.vpp_p;
  assign vpp_on = s_reg.vpp_o;
  assign busy = s_reg.st != ERPS_IDLE;
  assign done = s_reg.done;
  assign fail = s_reg.fail;
  assign id_maker = s_reg.idm;
  assign id_type = s_reg.idt;
endmodule

// ---- erps_mem_model.sv ----
`timescale 1ns/10ps
module erps_mem_model #(
  parameter int ADDR_W = 2,
  // Identification values are arbitrary.
  parameter logic [7:0] MAKER_CODE = 8'h5a,
  parameter logic [7:0] TYPE_CODE = 8'ha3
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic chip_en_n,
  input wire logic out_en_n,
  input wire logic program_strobe_n,
  input wire logic id_select_hv,
  input wire logic [7:0] mem_data_out,
  input wire logic mem_data_oe_n,
  input wire logic vpp_prog,
  output logic [7:0] mem_data_in
);
  logic [7:0] mem [2**ADDR_W];
  int need [2**ADDR_W];
  int hits [2**ADDR_W];
  logic [7:0] last = 8'h00;
  always @(posedge clock) begin
    last <= mem_data_in;
    if (srst) begin
      foreach (mem[i]) begin
        mem[i] = 8'hff;
        need[i] = 1;
        hits[i] = 0;
      end
    end
  end
  // A byte takes its data only once it has seen the pulses it needs.
  always @(posedge program_strobe_n) begin
    if (!chip_en_n && vpp_prog && !mem_data_oe_n) begin
      hits[mem_addr] = hits[mem_addr] + 1;
      if (hits[mem_addr] >= need[mem_addr]) mem[mem_addr] = mem[mem_addr] & mem_data_out;
    end
  end
  // Undriven pins show a pattern that flips every cycle.
  assign mem_data_in = (chip_en_n || out_en_n || !mem_data_oe_n) ? ~last :
    id_select_hv ? (mem_addr[0] ? TYPE_CODE : MAKER_CODE) : mem[mem_addr];
endmodule

// ---- erps_sequencer_sva.sv ----
`timescale 1ns/10ps
module erps_sequencer_sva #(
  parameter int ADDR_W = 17,
  parameter int PW_CYC = 2500
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic out_en_n,
  input wire logic program_strobe_n,
  input wire logic id_select_hv,
  input wire logic mem_data_oe_n,
  input wire logic vcc_prog,
  input wire logic vcc_on,
  input wire logic vpp_prog,
  input wire logic vpp_on,
  input wire logic done,
  input wire logic fail
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic [15:0] low_cnt_reg;
  always_ff @(posedge clock) begin
    if (srst || program_strobe_n) low_cnt_reg <= 16'h0;
    else low_cnt_reg <= low_cnt_reg + 16'h1;
  end
  property p_pw; $rose(program_strobe_n) |-> low_cnt_reg == PW_CYC; endproperty
  a_pw: assert property (p_pw) else $error("strobe width wrong");
  property p_hv; !program_strobe_n |-> vcc_prog && vpp_prog && vpp_on && vcc_on; endproperty
  a_hv: assert property (p_hv) else $error("pulse without supplies");
  property p_order; vpp_on |-> vcc_on; endproperty
  a_order: assert property (p_order) else $error("vpp without vcc");
  property p_off; $fell(vcc_on) |-> !$past(vpp_on); endproperty
  a_off: assert property (p_off) else $error("vcc removed first");
  property p_low; $fell(vpp_prog) |-> ##[0:200] !vcc_prog; endproperty
  a_low: assert property (p_low) else $error("vcc not lowered");
  property p_read; !out_en_n |-> program_strobe_n && mem_data_oe_n; endproperty
  a_read: assert property (p_read) else $error("read while driving");
  property p_addr; !program_strobe_n |-> $stable(mem_addr); endproperty
  a_addr: assert property (p_addr) else $error("address moved in pulse");
  property p_id; id_select_hv |-> program_strobe_n && !vpp_on; endproperty
  a_id: assert property (p_id) else $error("id mode while programming");
  property p_done; $rose(done) |-> !vpp_on && !id_select_hv; endproperty
  a_done: assert property (p_done) else $error("done with supply high");
  c_fail: cover property ($rose(fail));
  c_pass: cover property ($rose(done) && !fail);
  c_id: cover property ($rose(id_select_hv));
endmodule
bind erps_sequencer erps_sequencer_sva #(.ADDR_W(ADDR_W), .PW_CYC(PW_CYC)) sva_u (
  .clock, .srst, .mem_addr, .out_en_n, .program_strobe_n, .id_select_hv, .mem_data_oe_n,
  .vcc_prog, .vcc_on, .vpp_prog, .vpp_on, .done, .fail);

// ---- erps_sequencer_tb.sv ----
`timescale 1ns/10ps
module erps_sequencer_tb;
  logic clock = 0, srst = 1, start_prog = 0, start_id = 0;
  logic [1:0] last_addr = 2'h3, data_addr, mem_addr;
  logic [7:0] data_in, mem_data_out, mem_data_in, id_maker, id_type;
  logic chip_en_n, out_en_n, program_strobe_n, id_select_hv, mem_data_oe_n;
  logic vcc_prog, vcc_on, vpp_prog, vpp_on, busy, done, fail;
  logic [7:0] img [4] = '{8'h3c, 8'ha5, 8'h00, 8'hc3};
  int n_fail = 0, compares = 0;
  assign data_in = img[data_addr];
  initial forever #20 clock = ~clock;
  erps_sequencer #(.ADDR_W(2), .PW_CYC(20)) dut_u (.*);
  erps_mem_model #(.ADDR_W(2)) mem_u (.*);
  task check(string what, logic [7:0] seen, logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task end_of_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task rst;
    srst <= 1;
    repeat (8) @(posedge clock);
    srst <= 0;
    @(posedge clock);
  endtask
  task run(bit id, bit spoil);
    int i;
    if (id) start_id <= 1;
    else start_prog <= 1;
    @(posedge clock);
    start_id <= 0;
    start_prog <= 0;
    @(posedge clock);
    check("busy", 8'(busy), 8'h01);
    for (i = 0; i < 30000 && done !== 1'h1; i++) begin
      // Spoil one intended byte once the supplies drop, so the final reread must flag it.
      if (spoil && vpp_on === 1'h1 && vpp_prog === 1'h0) img[3] <= 8'h00;
      @(posedge clock);
    end
    if (done !== 1'h1) begin
      check("timeout", 8'h01, 8'h00);
      end_of_test;
    end
    check("idle", 8'(busy), 8'h00);
  endtask
  task t_pass;
    rst;
    mem_u.need[2] = 11;
    run(0, 0);
    check("fail", 8'(fail), 8'h00);
    for (int a = 0; a < 4; a++) check("byte", mem_u.mem[a], img[a]);
    check("extra pulses", 8'(mem_u.hits[2]), 8'h0b);
    check("first pass", 8'(mem_u.hits[0]), 8'h01);
    check("supply off", 8'(vpp_on), 8'h00);
    check("main supply off", 8'(vcc_on), 8'h00);
    check("main supply low", 8'(vcc_prog), 8'h00);
  endtask
  task t_fail;
    rst;
    mem_u.need[1] = 12;
    run(0, 0);
    check("fail", 8'(fail), 8'h01);
    check("pulses", 8'(mem_u.hits[1]), 8'h0b);
    check("last addr pulse", 8'(mem_u.hits[3]), 8'h01);
  endtask
  task t_reread;
    rst;
    run(0, 1);
    check("reread fail", 8'(fail), 8'h01);
    check("byte kept", mem_u.mem[3], 8'hc3);
    img[3] <= 8'hc3;
  endtask
  task t_id;
    run(1, 0);
    check("maker", id_maker, 8'h5a);
    check("type", id_type, 8'ha3);
  endtask
  initial begin
    t_pass;
    t_fail;
    t_reread;
    t_id;
    end_of_test;
  end
endmodule
